// file: pkg/pflt_pkg.sv
package pflt_pkg;

  // Register map (offsets are local choices)
  localparam logic [3:0] ADDR_PRIMARY_TRIG = 4'h0;
  localparam logic [3:0] ADDR_FAULT_LIMIT  = 4'h1;
  localparam logic [3:0] ADDR_SECOND_TRIG  = 4'h2;
  localparam logic [3:0] ADDR_OUT_CONTROL  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK     = 4'h5;
  localparam logic [3:0] ADDR_STATUS       = 4'h6;
  localparam logic [3:0] ADDR_LATCH_CLEAR  = 4'h7;

  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] CMP_MASK    = 16'hFFF8;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;

  // Source select decoding
  localparam logic [4:0] SRC_CMP_LAST   = 5'h03;
  localparam logic [4:0] SRC_FAULT_BASE = 5'h08;
  localparam logic [4:0] SRC_FAULT_LAST = 5'h1E;
  localparam int         NUM_CMP        = 4;
  localparam int         NUM_FAULT      = 23;

  // Trip mode codes
  localparam logic [1:0] TRIP_LATCHED  = 2'h0;
  localparam logic [1:0] TRIP_CYCLE    = 2'h1;
  localparam logic [1:0] TRIP_RESERVED = 2'h2;
  localparam logic [1:0] TRIP_DISABLED = 2'h3;

  // Interrupt bit positions
  localparam int IRQ_PRIMARY = 0;
  localparam int IRQ_TRIP    = 1;
  localparam int IRQ_LIMIT   = 2;
  localparam int IRQ_WIDTH   = 3;

  typedef struct packed {
    logic       independent_fault_mode;
    logic [4:0] limit_source_select;
    logic       limit_polarity;
    logic       limit_mode_enable;
    logic [4:0] trip_source_select;
    logic       trip_polarity;
    logic [1:0] trip_mode;
  } pflt_ctl_s;

  // Output control: bits 15..6 zero, 5:4 trip state, 3:2 limit state, 1 polh, 0 poll
  typedef struct packed {
    logic [9:0] unused;
    logic [1:0] trip_output_state;
    logic [1:0] limit_output_state;
    logic       high_pol_low;
    logic       low_pol_low;
  } pflt_out_s;

endpackage : pflt_pkg

// file: src/pflt_ctl.sv
// What this block does
// RQ1 - Primary compare in bits 15:3, low zero
// RQ2 - Secondary compare in bits 15:3, low zero
// RQ3 - Secondary match never raises trigger interrupt
// RQ4 - Independent mode: limit drives high, trip low
// RQ5 - Normal mode: each source forces both outputs
// RQ6 - Limit select: comparators, faults, reserved codes
// RQ7 - Selected limit signal feeds deadtime compensation
// RQ8 - Limit polarity one means active low
// RQ9 - Limit source acts only when enabled
// RQ10 - Trip select uses same decoding
// RQ11 - Trip polarity one means active low
// RQ12 - Trip mode: latched, cycle, reserved, disabled
// RQ13 - Software changes mode/polarity only when disabled
// RQ14 - Software avoids shared fault line, limit case
// RQ15 - Software avoids shared fault line, trip case
// RQ16 - Forced states pass through output polarity
// RQ17 - Cycle release at period boundary; latched held
// RQ18 - Trigger when counter equals compare value
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module pflt_ctl
  import pflt_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  clk_en,
  // Register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  // Time base and generator
  input  wire logic                  module_enable,
  input  wire logic [15:0]           local_count,
  input  wire logic                  period_boundary,
  input  wire logic                  gen_high,
  input  wire logic                  gen_low,
  // Sources
  input  wire logic [NUM_CMP-1:0]    comparator_in,
  input  wire logic [NUM_FAULT-1:0]  fault_in,
  // Outputs
  output logic                       high_output,
  output logic                       low_output,
  output logic                       deadtime_comp_input,
  output logic                       primary_trigger,
  output logic                       secondary_trigger,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Overview of the channel
  // Two sources per generator: a trip source and a limit source, each picked
  // from four comparators or twenty-three fault lines by a five-bit code.
  // In normal mode either forces the pin pair, in independent mode limit the high pin and trip the low; forced values are in active terms, so
  // the pin polarity bits apply to forced and normal levels alike.
  // Limitation: polarity and mode bits are not guarded against writes while
  // the generator runs; software keeps to the quiet window on its own.
  // Trade-off: every pin and trigger output is registered, which costs one
  // cycle of reaction but gives glitch-free levels at the pins.

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] primary_trigger_compare;
  logic [15:0] secondary_trigger_compare;
  pflt_ctl_s   fault_limit_control;
  pflt_out_s   out_control;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic        trip_held;
  logic        limit_held;
  logic [15:0] next_primary;
  logic [15:0] next_secondary;
  pflt_ctl_s   next_fcl;
  pflt_out_s   next_out;
  logic [IRQ_WIDTH-1:0] next_irq_status;
  logic [IRQ_WIDTH-1:0] next_irq_mask;
  logic        next_trip_held;
  logic        next_limit_held;
  logic [15:0] next_rdata;
  logic        next_high;
  logic        next_low;
  logic        next_dtc;
  logic        next_ptrig;
  logic        next_strig;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection, shared decoder for both selects
  function automatic logic pick_source(input logic [4:0] sel,
                                       input logic [NUM_CMP-1:0] cmp,
                                       input logic [NUM_FAULT-1:0] flt);
    logic [4:0] idx;
    idx = 5'h00;
    pick_source = 1'b0;
    if (sel <= SRC_CMP_LAST) begin
      pick_source = cmp[sel[1:0]];                          // [RQ6] [RQ10]
    end else if (sel >= SRC_FAULT_BASE && sel <= SRC_FAULT_LAST) begin
      idx = sel - SRC_FAULT_BASE;
      pick_source = flt[idx];                               // [RQ6] [RQ10]
    end
    // Reserved codes select nothing and read as zero, which counts as active when the polarity bit is one
  endfunction : pick_source

  logic limit_raw;
  logic trip_raw;
  logic limit_active;
  logic trip_active;
  logic trip_enabled;

  // Polarity and enable qualification
  always_comb begin
    limit_raw    = pick_source(fault_limit_control.limit_source_select,
                               comparator_in, fault_in);
    trip_raw     = pick_source(fault_limit_control.trip_source_select,
                               comparator_in, fault_in);
    limit_active = (limit_raw ^ fault_limit_control.limit_polarity)     // [RQ8]
                   & fault_limit_control.limit_mode_enable;              // [RQ9]
    trip_enabled = (fault_limit_control.trip_mode == TRIP_LATCHED) ||
                   (fault_limit_control.trip_mode == TRIP_CYCLE);        // [RQ12]
    trip_active  = (trip_raw ^ fault_limit_control.trip_polarity)       // [RQ11]
                   & trip_enabled;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, hold state, triggers and outputs
  logic       wr_fcl;
  logic       trip_force;
  logic       limit_force;
  logic       act_high;
  logic       act_low;
  logic [IRQ_WIDTH-1:0] events;
  logic [IRQ_WIDTH-1:0] w1c;
  logic       latch_clr;

  // Register file: writes, write-one-clear strobes and the latch release request
  // Low compare bits are dropped on the way in, so they can never read back
  always_comb begin
    next_primary    = primary_trigger_compare;
    next_secondary  = secondary_trigger_compare;
    next_fcl        = fault_limit_control;
    next_out        = out_control;
    next_irq_mask   = irq_mask;
    latch_clr       = 1'b0;
    wr_fcl          = 1'b0;
    w1c             = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PRIMARY_TRIG: next_primary   = reg_wdata & CMP_MASK;        // [RQ1]
        ADDR_SECOND_TRIG:  next_secondary = reg_wdata & CMP_MASK;        // [RQ2]
        ADDR_FAULT_LIMIT: begin
          next_fcl = pflt_ctl_s'(reg_wdata);
          wr_fcl   = 1'b1;
        end
        ADDR_OUT_CONTROL: begin
          next_out        = pflt_out_s'(reg_wdata);
          next_out.unused = '0;
        end
        ADDR_IRQ_STATUS:  w1c           = reg_wdata[IRQ_WIDTH-1:0];
        ADDR_IRQ_MASK:    next_irq_mask = reg_wdata[IRQ_WIDTH-1:0];
        ADDR_LATCH_CLEAR: begin
          // Software release of a latched trip, only once the input is gone
          // Only a request here; the hold logic decides whether it takes
          latch_clr = reg_wdata[0];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold state: a source that went active keeps forcing until its release
  // point, so a short glitch still holds the pins for the rest of the period
  always_comb begin
    next_trip_held  = trip_held;
    next_limit_held = limit_held;
    // Latched trip leaves on request, never while the input is still on, or on a reconfiguration write
    if (latch_clr && !trip_active) begin
      next_trip_held = 1'b0;                                             // [RQ17]
    end
    // Cycle mode releases at the period boundary when the input is gone
    if (fault_limit_control.trip_mode == TRIP_CYCLE && period_boundary && !trip_active) begin
      next_trip_held = 1'b0;                                             // [RQ17]
    end
    if (!trip_enabled) begin
      next_trip_held = 1'b0;
    end
    // Limit is cycle-by-cycle by nature
    if (period_boundary && !limit_active) begin
      next_limit_held = 1'b0;
    end
    if (!fault_limit_control.limit_mode_enable) begin
      next_limit_held = 1'b0;
    end
    // New activity wins over every release except a reconfiguration write
    if (trip_active) begin
      next_trip_held = 1'b1;                                             // [RQ12]
    end
    if (limit_active) begin
      next_limit_held = 1'b1;
    end
    // Reconfiguration drops the trip hold, even one raised in this cycle
    if (wr_fcl) begin
      next_trip_held = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin levels: forcing is worked out in active/inactive terms first, and
  // the pin polarity is applied last so forced and normal levels flip alike
  always_comb begin
    trip_force  = trip_active | trip_held;
    limit_force = limit_active | limit_held;
    // Forcing in active/inactive terms
    act_high = gen_high;
    act_low  = gen_low;
    if (fault_limit_control.independent_fault_mode) begin
      if (limit_force) act_high = out_control.trip_output_state[1];     // [RQ4]
      if (trip_force)  act_low  = out_control.trip_output_state[0];     // [RQ4]
    end else if (trip_force) begin
      act_high = out_control.trip_output_state[1];                      // [RQ5]
      act_low  = out_control.trip_output_state[0];                      // [RQ5]
    end else if (limit_force) begin
      act_high = out_control.limit_output_state[1];                     // [RQ5]
      act_low  = out_control.limit_output_state[0];                     // [RQ5]
    end
    next_high  = act_high ^ out_control.high_pol_low;                   // [RQ16]
    next_low   = act_low ^ out_control.low_pol_low;                     // [RQ16]
    // Raw line before polarity, as the compensation logic expects
    next_dtc   = limit_raw;                                             // [RQ7]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger compares; the three dropped count bits keep each match
  // standing for eight counts, so the interrupt keys on its rising edge
  always_comb begin
    next_ptrig = module_enable &&
                 ((local_count & CMP_MASK) == primary_trigger_compare);   // [RQ18]
    next_strig = module_enable &&
                 ((local_count & CMP_MASK) == secondary_trigger_compare); // [RQ18]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status; a secondary match has no path in here at all
  always_comb begin
    // Only the primary path feeds the trigger interrupt
    events = '0;
    events[IRQ_PRIMARY] = next_ptrig && !primary_trigger;                // [RQ3]
    events[IRQ_TRIP]    = trip_active && !trip_held;
    events[IRQ_LIMIT]   = limit_active && !limit_held;
    // Set wins over write-one clear
    // An event in the clearing cycle survives the clear
    next_irq_status = (irq_status & ~w1c) | events;
  end

  // Read mux
  always_comb begin
    next_rdata = ZERO_WORD;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PRIMARY_TRIG: next_rdata = primary_trigger_compare;         // [RQ1]
        ADDR_SECOND_TRIG:  next_rdata = secondary_trigger_compare;       // [RQ2]
        ADDR_FAULT_LIMIT:  next_rdata = fault_limit_control;
        ADDR_OUT_CONTROL:  next_rdata = out_control;
        ADDR_IRQ_STATUS:   next_rdata = {13'h0000, irq_status};
        ADDR_IRQ_MASK:     next_rdata = {13'h0000, irq_mask};
        ADDR_STATUS:       next_rdata = {11'h000, limit_raw, trip_raw,
                                         limit_force, trip_force, trip_held};
        default:           next_rdata = ZERO_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file state; a low clock enable freezes reads as well
  always_ff @(posedge clk) begin
    if (srst) begin
      primary_trigger_compare   <= RESET_VALUE;
      secondary_trigger_compare <= RESET_VALUE;
      fault_limit_control       <= pflt_ctl_s'(RESET_VALUE);
      out_control               <= pflt_out_s'(RESET_VALUE);
      irq_status                <= '0;
      irq_mask                  <= '0;
      reg_rdata                 <= ZERO_WORD;
    end else if (clk_en) begin
      primary_trigger_compare   <= next_primary;
      secondary_trigger_compare <= next_secondary;
      fault_limit_control       <= next_fcl;
      out_control               <= next_out;
      irq_status                <= next_irq_status;
      irq_mask                  <= next_irq_mask;
      reg_rdata                 <= next_rdata;
    end
  end

  // Hold state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      trip_held                 <= 1'b0;
      limit_held                <= 1'b0;
    end else if (clk_en) begin
      trip_held                 <= next_trip_held;
      limit_held                <= next_limit_held;
    end
  end

  // Pin and trigger outputs, registered so the pins never glitch
  always_ff @(posedge clk) begin
    if (srst) begin
      high_output               <= 1'b0;
      low_output                <= 1'b0;
      deadtime_comp_input       <= 1'b0;
      primary_trigger           <= 1'b0;
      secondary_trigger         <= 1'b0;
    end else if (clk_en) begin
      high_output               <= next_high;
      low_output                <= next_low;
      deadtime_comp_input       <= next_dtc;
      primary_trigger           <= next_ptrig;
      secondary_trigger         <= next_strig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level interrupt from unmasked sticky bits; it stays high until software
  // clears the status bit, so a missed edge cannot lose an event
  assign irq = |(irq_status & irq_mask);

endmodule : pflt_ctl

`default_nettype wire

// file: dv/pflt_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module pflt_src_model
  import pflt_pkg::*;
#(parameter int PER = 64)
(
  // Bench control
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 run,
  input  wire logic                 stb,
  input  wire logic [4:0]           code,
  input  wire logic                 val,
  // Toward the block
  output logic      [15:0]          local_count,
  output logic                      period_boundary,
  output logic      [NUM_CMP-1:0]   comparator_in,
  output logic      [NUM_FAULT-1:0] fault_in
);
  // Free time base; a line keeps the level last set, codes out of range touch nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      local_count <= '0;
      period_boundary <= 1'b0;
      comparator_in <= '0;
      fault_in <= '0;
    end else begin
      if (run) local_count <= (local_count == PER - 1) ? 16'h0000 : local_count + 16'h0001;
      period_boundary <= run && (local_count == PER - 1);
      if (stb && code <= SRC_CMP_LAST) comparator_in[code[1:0]] <= val;
      if (stb && code >= SRC_FAULT_BASE && code <= SRC_FAULT_LAST)
        fault_in[code - SRC_FAULT_BASE] <= val;
    end
  end
endmodule : pflt_src_model

`default_nettype wire

// file: dv/pflt_ctl_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module pflt_ctl_monitor
  import pflt_pkg::*;
(
  // Clock and register port
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  input  wire logic [3:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [15:0]          reg_rdata,
  // Sources and results
  input  wire logic                 module_enable,
  input  wire logic [15:0]          local_count,
  input  wire logic [NUM_CMP-1:0]   comparator_in,
  input  wire logic [NUM_FAULT-1:0] fault_in,
  input  wire logic                 deadtime_comp_input,
  input  wire logic                 primary_trigger,
  input  wire logic                 secondary_trigger,
  input  wire logic                 irq
);
  logic [15:0] pcmp, scmp, fcl;
  logic [2:0]  msk;
  logic        lv, ls;
  //////////////////////////////////////////////////////////////////////////////
  // Shadow copies, since the checks may only look at the ports
  always_ff @(posedge clk) begin
    if (srst) begin
      {pcmp, scmp, fcl, msk} <= '0;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        ADDR_PRIMARY_TRIG: pcmp <= reg_wdata;
        ADDR_SECOND_TRIG:  scmp <= reg_wdata;
        ADDR_FAULT_LIMIT:  fcl <= reg_wdata;
        ADDR_IRQ_MASK:     msk <= reg_wdata[2:0];
        default:           msk <= msk;
      endcase
    end
  end
  // Selected limit line; reserved codes are left out of the check
  always_comb begin
    lv = 1'b1;
    ls = 1'b0;
    if (fcl[14:10] <= SRC_CMP_LAST) ls = comparator_in[fcl[11:10]];
    else if (fcl[14:10] >= SRC_FAULT_BASE && fcl[14:10] <= SRC_FAULT_LAST)
      ls = fault_in[fcl[14:10] - SRC_FAULT_BASE];
    else lv = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_cmp_read;
    clk_en && reg_rd && (reg_addr == ADDR_PRIMARY_TRIG || reg_addr == ADDR_SECOND_TRIG);
  endsequence
  chk_rd_idle: assert property (clk_en && !reg_rd |=> reg_rdata == ZERO_WORD)
    else $error("read data not zero outside answer");
  chk_cmp_lowz: assert property (s_cmp_read |=> reg_rdata[2:0] == 3'h0)
    else $error("compare low bits not zero");
  chk_rd_unmap: assert property (clk_en && reg_rd && reg_addr[3] |=> reg_rdata == ZERO_WORD)
    else $error("unmapped read not zero");
  chk_pri_trig: assert property (clk_en |=> primary_trigger ==
    $past(module_enable && local_count[15:3] == pcmp[15:3])) else $error("primary trigger");
  chk_sec_trig: assert property (clk_en |=> secondary_trigger ==
    $past(module_enable && local_count[15:3] == scmp[15:3])) else $error("secondary trigger");
  chk_dtc_src: assert property (clk_en && lv |=> deadtime_comp_input == $past(ls))
    else $error("deadtime input not selected line");
  chk_irq_mask: assert property (msk == 3'h0 |-> !irq)
    else $error("interrupt with all masked");
  chk_sec_noirq: assert property (msk == 3'h1 && $stable(msk) && $rose(irq) |->
    primary_trigger || $past(primary_trigger)) else $error("interrupt without primary");
endmodule : pflt_ctl_monitor

bind pflt_ctl pflt_ctl_monitor u_mon (.*);

`default_nettype wire

// file: dv/pflt_ctl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module pflt_ctl_tb
  import pflt_pkg::*;
;
  logic clk, srst, clk_en, reg_wr, reg_rd, module_enable, period_boundary, gen_high, gen_low;
  logic high_output, low_output, deadtime_comp_input, primary_trigger, secondary_trigger, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, local_count, d;
  logic [NUM_CMP-1:0] comparator_in;
  logic [NUM_FAULT-1:0] fault_in;
  logic run, stb, val, lp, tp, gh, gl;
  logic [4:0] scode, code5;
  logic [1:0] pol, ts, lsd, u, f;
  int error_cnt, n_compared, i, m, c;

  pflt_ctl dut (.*);
  pflt_src_model src (.clk(clk), .srst(srst), .run(run), .stb(stb), .code(scode), .val(val),
    .local_count(local_count), .period_boundary(period_boundary),
    .comparator_in(comparator_in), .fault_in(fault_in));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; whole run is about 1600 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog", $time);
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the read edge
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e, "read");
  endtask : rd_chk
  task automatic line(input logic [4:0] c5, input logic v);
    @(posedge clk);
    scode <= c5;
    val <= v;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
  endtask : line
  task automatic pins(input logic [4:0] c5, input logic v, input int w, input logic [1:0] e);
    line(c5, v);
    repeat (w) @(posedge clk);
    @(negedge clk);
    chk({14'h0000, high_output, low_output}, {14'h0000, e}, "pins");
  endtask : pins
  // Expected pin pair from active levels and the active-low polarity bits
  function automatic logic [1:0] pin_lvl(input logic [1:0] act, input logic [1:0] p);
    return act ^ p;
  endfunction : pin_lvl
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {srst, clk_en} = 2'b11;
    {reg_wr, reg_rd, module_enable, gen_high, gen_low, run, stb, val} = '0;
    {reg_addr, reg_wdata, scode} = '0;
    {error_cnt, n_compared} = '0;
    void'($urandom(32'h650c));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // Reset values, readback masks, unmapped place
    for (i = 0; i < 9; i++) rd_chk(i[3:0], RESET_VALUE);
    for (i = 0; i < 4; i++) begin
      d = 16'($urandom());
      wr(ADDR_PRIMARY_TRIG, d);
      rd_chk(ADDR_PRIMARY_TRIG, d & CMP_MASK);
      wr(ADDR_SECOND_TRIG, ~d);
      rd_chk(ADDR_SECOND_TRIG, ~d & CMP_MASK);
      wr(ADDR_FAULT_LIMIT, d);
      rd_chk(ADDR_FAULT_LIMIT, d);
      wr(4'hC, d);
      rd_chk(4'hC, ZERO_WORD);
    end
    $display("registers done");
    // Only the primary match may interrupt
    run <= 1'b1;
    wr(ADDR_PRIMARY_TRIG, 16'hFFF8);
    wr(ADDR_SECOND_TRIG, 16'h0028);
    wr(ADDR_IRQ_MASK, 16'h0001);
    wr(ADDR_IRQ_STATUS, 16'h0007);
    module_enable <= 1'b1;
    repeat (80) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000, "secondary irq");
    wr(ADDR_PRIMARY_TRIG, 16'h0010);
    repeat (80) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001, "primary irq");
    module_enable <= 1'b0;
    wr(ADDR_IRQ_STATUS, 16'h0001);
    @(negedge clk);
    chk({15'h0000, irq}, 16'h0000, "irq clear");
    $display("triggers done");
    // Limit forcing in normal mode over random sources and levels
    for (i = 0; i < 6; i++) begin
      c = $urandom_range(26);
      code5 = (c < 4) ? c[4:0] : c[4:0] + 5'h04;
      {pol, ts, lsd, lp, gh, gl} = 9'($urandom());
      u = pin_lvl({gh, gl}, pol);
      gen_high <= gh;
      gen_low <= gl;
      wr(ADDR_OUT_CONTROL, {10'h000, ts, lsd, pol});
      wr(ADDR_FAULT_LIMIT, {1'b0, code5, lp, i != 0, 5'h1E, 1'b0, TRIP_DISABLED});
      pins(code5, lp, 70, u);
      pins(code5, ~lp, 4, (i != 0) ? pin_lvl(lsd, pol) : u);
      pins(code5, lp, 70, u);
    end
    $display("limit done");
    // Every trip mode: onset, release, latched clear
    tp = 1'($urandom());
    f = pin_lvl(ts, pol);
    for (m = 0; m < 4; m++) begin
      wr(ADDR_FAULT_LIMIT, {1'b0, 5'h1F, 2'b00, 5'h08, tp, m[1:0]});
      pins(5'h08, ~tp, 4, (m < 2) ? f : u);
      pins(5'h08, tp, 70, (m == 0) ? f : u);
      wr(ADDR_LATCH_CLEAR, 16'h0001);
      pins(5'h08, tp, 4, u);
    end
    $display("trip done");
    // Independent mapping: limit to high pin, trip to low pin
    line(5'h00, 1'b0);
    line(5'h09, 1'b0);
    wr(ADDR_FAULT_LIMIT, {1'b1, 5'h00, 2'b01, 5'h09, 1'b0, TRIP_CYCLE});
    pins(5'h00, 1'b1, 4, {f[1], u[0]});
    pins(5'h09, 1'b1, 4, f);
    $display("independent done");
    report_and_stop();
  end
endmodule : pflt_ctl_tb

`default_nettype wire
